/* rtl/cmdbg_top.v */
// can mode change and debug state block, top level with registers
`timescale 1ns/1ps
`include "cmdbg_regs.vh"
module cmdbg_top (
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // protocol engine side
  input  wire        tx_start,
  input  wire        tx_done,
  input  wire        bus_off,
  input  wire        dbg_msg_a,
  input  wire        dbg_msg_b,
  input  wire        dbg_msg_c,
  input  wire        dma_done,
  output wire        tx_fd,
  output wire        tx_brs,
  output reg         tx_abort,
  output wire        dma_req,
  // interrupt
  output wire        irq
);
  localparam NB = `CMDBG_NBUF;
  localparam PW = `CMDBG_EVT_PTR_W;

  reg  [7:0]           cc_reg;
  reg  [NB-1:0]        pend_reg;
  reg  [`CMDBG_IRQ_W-1:0] flags_reg;
  reg  [`CMDBG_IRQ_W-1:0] mask_reg;
  reg  [1:0]           evt_mem [0:`CMDBG_EVT_DEPTH-1];
  reg  [PW-1:0]        wp_reg;
  reg  [PW-1:0]        rp_reg;
  reg  [PW:0]          cnt_reg;
  reg                  fd_prev_reg;
  reg                  active_reg;
  wire [1:0]           debug_msg_state_field;
  wire [1:0]           mode;
  wire                 cap_fd;
  wire                 cap_brs;
  wire                 wr_cc;
  wire                 fail_start;
  wire                 good_start;
  wire                 evt_push;
  wire                 evt_pop;
  wire [`CMDBG_IRQ_W-1:0] ev_set;
  wire [NB-1:0]        pend_clr;
  wire [NB-1:0]        pend_set;

  assign mode  = cc_reg[`CMDBG_CC_MODE_HI:`CMDBG_CC_MODE_LO];
  assign wr_cc = reg_wr && (reg_addr == `CMDBG_OFS_CORE_CTRL);
  // fd to classic coinciding with a start: mode changes this cycle while
  // the last captured format was fd
  // a start while restricted is refused, so it cannot abort twice
  assign fail_start = tx_start && wr_cc && fd_prev_reg &&
    !cc_reg[`CMDBG_CC_RESTR] &&
    (reg_wdata[`CMDBG_CC_MODE_HI:`CMDBG_CC_MODE_LO] ==
     `CMDBG_MODE_CLASSIC);
  assign good_start = tx_start && !fail_start &&
    !cc_reg[`CMDBG_CC_RESTR];
  assign evt_pop  = reg_rd && (reg_addr == `CMDBG_OFS_EVT_FIFO) &&
    (cnt_reg != 0);
  // a full fifo still takes a record when a pop frees a slot this cycle
  assign evt_push = tx_done && active_reg &&
    ((cnt_reg != `CMDBG_EVT_DEPTH) || evt_pop);
  assign pend_clr = ((tx_done && active_reg) || fail_start) ?
    (pend_reg & (pend_reg - 1'b1)) : pend_reg;
  assign pend_set = (reg_wr && reg_addr == `CMDBG_OFS_TX_SET) ?
    reg_wdata[NB-1:0] : {NB{1'b0}};
  assign ev_set = {fail_start, evt_push, fail_start};
  assign tx_fd  = cap_fd;
  assign tx_brs = cap_brs;
  assign irq    = |(flags_reg & mask_reg);

  cmdbg_frame_cap u_cap (
    .clk_sys            (clk_sys),
    .reset_n            (reset_n),
    .tx_start           (good_start),
    .mode_request_field (mode),
    .fd_reg             (cap_fd),
    .brs_reg            (cap_brs)
  );

  cmdbg_dbg_fsm u_dbg (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .init      (cc_reg[`CMDBG_CC_INIT]),
    .bus_off   (bus_off),
    .dbg_msg_a (dbg_msg_a),
    .dbg_msg_b (dbg_msg_b),
    .dbg_msg_c (dbg_msg_c),
    .dma_done  (dma_done),
    .state_reg (debug_msg_state_field),
    .dma_req   (dma_req)
  );

  // core control; init gates the restr write, cce is stored only and never touches dms
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      cc_reg <= `CMDBG_CC_RESET;
    end else begin
      if (wr_cc) begin
        cc_reg[`CMDBG_CC_INIT] <= reg_wdata[`CMDBG_CC_INIT];
        cc_reg[`CMDBG_CC_CCE]  <= reg_wdata[`CMDBG_CC_CCE];
        cc_reg[7:3] <= {2'h0, reg_wdata[5:4], 1'b0};
        if (reg_wdata[`CMDBG_CC_INIT])
          cc_reg[`CMDBG_CC_RESTR] <= reg_wdata[`CMDBG_CC_RESTR];
      end
      if (fail_start)
        cc_reg[`CMDBG_CC_RESTR] <= 1'b1;
    end
  end

  // pending requests: set by software, cleared on completion or abort
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pend_reg    <= {NB{1'b0}};
      active_reg  <= 1'b0;
      fd_prev_reg <= 1'b0;
      tx_abort    <= 1'b0;
    end else begin
      tx_abort <= fail_start;
      if (good_start) begin
        active_reg  <= 1'b1;
        fd_prev_reg <= (mode != `CMDBG_MODE_CLASSIC);
      end else if (tx_done || fail_start) begin
        active_reg <= 1'b0;
      end
      // a set and a completion in one cycle must both take effect
      pend_reg <= pend_clr | pend_set;
    end
  end

  // event fifo, record taken from the captured format
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      wp_reg  <= {PW{1'b0}};
      rp_reg  <= {PW{1'b0}};
      cnt_reg <= {(PW+1){1'b0}};
    end else begin
      if (evt_push) begin
        evt_mem[wp_reg] <= {cap_brs, cap_fd};
        wp_reg <= wp_reg + 1'b1;
      end
      if (evt_pop)
        rp_reg <= rp_reg + 1'b1;
      if (evt_push && !evt_pop)
        cnt_reg <= cnt_reg + 1'b1;
      else if (evt_pop && !evt_push)
        cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // sticky flags, write one to clear, set wins
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      flags_reg <= {`CMDBG_IRQ_W{1'b0}};
      mask_reg  <= {`CMDBG_IRQ_W{1'b0}};
    end else begin
      if (reg_wr && reg_addr == `CMDBG_OFS_IRQ_FLAGS)
        flags_reg <= (flags_reg & ~reg_wdata[`CMDBG_IRQ_W-1:0]) | ev_set;
      else
        flags_reg <= flags_reg | ev_set;
      if (reg_wr && reg_addr == `CMDBG_OFS_IRQ_MASK)
        mask_reg <= reg_wdata[`CMDBG_IRQ_W-1:0];
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `CMDBG_OFS_CORE_CTRL: reg_rdata <= {24'h0, cc_reg};
        `CMDBG_OFS_TX_PEND:   reg_rdata <= {28'h0, pend_reg};
        `CMDBG_OFS_IRQ_FLAGS: reg_rdata <= {29'h0, flags_reg};
        `CMDBG_OFS_IRQ_MASK:  reg_rdata <= {29'h0, mask_reg};
        `CMDBG_OFS_RXF1_STAT: reg_rdata <= {30'h0, debug_msg_state_field};
        `CMDBG_OFS_EVT_FIFO:
          reg_rdata <= (cnt_reg != 0) ?
            {30'h0, evt_mem[rp_reg]} : 32'h0;
        `CMDBG_OFS_EVT_STAT:  reg_rdata <= {29'h0, cnt_reg};
        `CMDBG_OFS_ID:        reg_rdata <= `CMDBG_ID_VALUE;
        default:              reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule

/* rtl/cmdbg_regs.vh */
// register offsets, field positions, reset values and codes for cmdbg
`ifndef CMDBG_REGS_VH
`define CMDBG_REGS_VH
`define CMDBG_ADDR_W        4
`define CMDBG_OFS_CORE_CTRL 4'h0
`define CMDBG_OFS_TX_PEND   4'h1
`define CMDBG_OFS_IRQ_FLAGS 4'h2
`define CMDBG_OFS_IRQ_MASK  4'h3
`define CMDBG_OFS_RXF1_STAT 4'h4
`define CMDBG_OFS_EVT_FIFO  4'h5
`define CMDBG_OFS_EVT_STAT  4'h6
`define CMDBG_OFS_TX_SET    4'h7
`define CMDBG_OFS_ID        4'h8
// core control fields
`define CMDBG_CC_INIT       0
`define CMDBG_CC_CCE        1
`define CMDBG_CC_RESTR      2
`define CMDBG_CC_MODE_LO    4
`define CMDBG_CC_MODE_HI    5
// interrupt flag fields
`define CMDBG_IRQ_W         3
`define CMDBG_IRQ_MSG_RAM_ACCESS_FAIL_FLAG      0
`define CMDBG_IRQ_TXEV      1
`define CMDBG_IRQ_ABORT     2
// operating modes
`define CMDBG_MODE_CLASSIC  2'h0
`define CMDBG_MODE_FD       2'h1
`define CMDBG_MODE_FD_BRS   2'h2
// debug message states
`define CMDBG_DMS_IDLE      2'h0
`define CMDBG_DMS_A         2'h1
`define CMDBG_DMS_AB        2'h2
`define CMDBG_DMS_ABC       2'h3
// widths and reset values
`define CMDBG_NBUF          4
`define CMDBG_EVT_DEPTH     4
`define CMDBG_EVT_PTR_W     2
`define CMDBG_CC_RESET      8'h01
// identity value is arbitrary and names no maker or part
`define CMDBG_ID_VALUE      32'h00c0ffee
`endif

/* rtl/cmdbg_frame_cap.v */
// captures frame format once at the start of a transmission
`timescale 1ns/1ps
`include "cmdbg_regs.vh"
module cmdbg_frame_cap (
  // clock and reset
  input  wire       clk_sys,
  input  wire       reset_n,
  // control
  input  wire       tx_start,
  input  wire [1:0] mode_request_field,
  // captured format
  output reg        fd_reg,
  output reg        brs_reg
);
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      fd_reg  <= 1'b0;
      brs_reg <= 1'b0;
    end else if (tx_start) begin
      // one capture serves the bus frame and the event record
      fd_reg  <= (mode_request_field != `CMDBG_MODE_CLASSIC);
      brs_reg <= (mode_request_field == `CMDBG_MODE_FD_BRS);
    end
  end
endmodule

/* rtl/cmdbg_dbg_fsm.v */
// debug message handling state machine
`timescale 1ns/1ps
`include "cmdbg_regs.vh"
module cmdbg_dbg_fsm (
  // clock and reset
  input  wire       clk_sys,
  input  wire       reset_n,
  // controls
  input  wire       init,
  input  wire       bus_off,
  input  wire       dbg_msg_a,
  input  wire       dbg_msg_b,
  input  wire       dbg_msg_c,
  input  wire       dma_done,
  // state
  output reg  [1:0] state_reg,
  output wire       dma_req
);
  reg [1:0] state_next;
  assign dma_req = (state_reg == `CMDBG_DMS_ABC);
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `CMDBG_DMS_IDLE: begin
        if (dbg_msg_a)
          state_next = `CMDBG_DMS_A;
      end
      `CMDBG_DMS_A: begin
        if (dbg_msg_b)
          state_next = `CMDBG_DMS_AB;
        else if (dbg_msg_a | dbg_msg_c)
          state_next = `CMDBG_DMS_IDLE;
      end
      `CMDBG_DMS_AB: begin
        if (dbg_msg_c)
          state_next = `CMDBG_DMS_ABC;
        else if (dbg_msg_a | dbg_msg_b)
          state_next = `CMDBG_DMS_IDLE;
      end
      `CMDBG_DMS_ABC: begin
        if (dma_done)
          state_next = `CMDBG_DMS_IDLE;
      end
      default: state_next = `CMDBG_DMS_IDLE;
    endcase
    // init or bus-off forces idle instead of holding
    if (init | bus_off)
      state_next = `CMDBG_DMS_IDLE;
  end
  always @(posedge clk_sys) begin
    if (!reset_n)
      state_reg <= `CMDBG_DMS_IDLE;
    else
      state_reg <= state_next;
  end
endmodule

/* tb/cmdbg_checker.sv */
// concurrent checks on the ports of the mode change and debug block
`timescale 1ns/1ps
module cmdbg_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // inputs watched
  input wire logic reg_wr,
  input wire logic tx_start,
  input wire logic bus_off,
  input wire logic dbg_msg_a,
  input wire logic dbg_msg_b,
  input wire logic dbg_msg_c,
  input wire logic dma_done,
  // outputs watched
  input wire logic tx_fd,
  input wire logic tx_brs,
  input wire logic tx_abort,
  input wire logic dma_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // bus-off first so the walk is known to start from idle
  sequence s_dbg_walk;
    bus_off ##1 dbg_msg_a ##1 dbg_msg_b ##1 dbg_msg_c;
  endsequence
  sequence s_abort_start;
    reg_wr && tx_start;
  endsequence
  a_dbg_walk_dma: assert property (s_dbg_walk |=> dma_req)
    else $error("debug walk did not reach dma state");
  a_dma_done_idle: assert property (dma_req && dma_done |=> !dma_req)
    else $error("dma request stayed after completion");
  a_dma_req_hold: assert property (
    dma_req && !dma_done && !bus_off && !reg_wr |=> dma_req)
    else $error("dma request dropped without cause");
  a_bus_off_idle: assert property (bus_off |=> !dma_req)
    else $error("bus-off did not idle debug state");
  a_abort_cause: assert property (tx_abort |-> $past(tx_start))
    else $error("abort without a start");
  a_abort_pulse: assert property (
    s_abort_start ##1 tx_abort |=> !tx_abort)
    else $error("abort longer than one cycle");
  a_format_hold: assert property (
    !tx_start |=> $stable(tx_fd) && $stable(tx_brs))
    else $error("frame format changed without a start");
  a_brs_needs_fd: assert property (tx_brs |-> tx_fd)
    else $error("rate switch without extended length");
endmodule
bind cmdbg_top cmdbg_checker u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr),
  .tx_start(tx_start), .bus_off(bus_off), .dbg_msg_a(dbg_msg_a),
  .dbg_msg_b(dbg_msg_b), .dbg_msg_c(dbg_msg_c), .dma_done(dma_done),
  .tx_fd(tx_fd), .tx_brs(tx_brs), .tx_abort(tx_abort), .dma_req(dma_req)
);

/* tb/cmdbg_engine_model.sv */
// far side model: finishes frames and serves dma requests
`timescale 1ns/1ps
module cmdbg_engine_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // from the bench and the block
  input  wire logic tx_start,
  input  wire logic tx_abort,
  input  wire logic dma_req,
  input  wire logic slow,
  // answers
  output logic      tx_done,
  output logic      dma_done
);
  integer tcnt;
  integer dcnt;
  // an aborted start never completes, so the count is dropped on abort
  always @(posedge clk_sys) begin
    tx_done <= 1'b0;
    dma_done <= 1'b0;
    if (!reset_n) begin
      tcnt <= 0;
      dcnt <= 0;
    end else begin
      if (tx_start) tcnt <= slow ? 9 : 2;
      else if (tx_abort) tcnt <= 0;
      else if (tcnt == 1) begin
        tx_done <= 1'b1;
        tcnt <= 0;
      end else if (tcnt > 1) tcnt <= tcnt - 1;
      if (dcnt == 1) begin
        dma_done <= 1'b1;
        dcnt <= 0;
      end else if (dcnt > 1) dcnt <= dcnt - 1;
      else if (dma_req && !dma_done) dcnt <= slow ? 8 : 2;
    end
  end
endmodule

/* tb/cmdbg_tb.sv */
// self-checking bench for the mode change and debug block
`timescale 1ns/1ps
`include "cmdbg_regs.vh"
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, x); end end
module testbench;
  logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic tx_start = 1'b0, bus_off = 1'b0, slow = 1'b0;
  logic dbg_msg_a = 1'b0, dbg_msg_b = 1'b0, dbg_msg_c = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, e;
  logic tx_done, dma_done, tx_fd, tx_brs, tx_abort, dma_req, irq;
  integer failures = 0, compares = 0, seed = 32'h67e7fc77, i, m, k;
  // reference model of the event fifo: expected records in start order
  integer q[$];
  cmdbg_top DUT (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tx_start(tx_start), .tx_done(tx_done),
    .bus_off(bus_off), .dbg_msg_a(dbg_msg_a), .dbg_msg_b(dbg_msg_b),
    .dbg_msg_c(dbg_msg_c), .dma_done(dma_done), .tx_fd(tx_fd),
    .tx_brs(tx_brs), .tx_abort(tx_abort), .dma_req(dma_req), .irq(irq));
  cmdbg_engine_model u_eng (.clk_sys(clk_sys), .reset_n(reset_n),
    .tx_start(tx_start), .tx_abort(tx_abort), .dma_req(dma_req),
    .slow(slow), .tx_done(tx_done), .dma_done(dma_done));
  initial forever #20 clk_sys = ~clk_sys;
  task wr(input [3:0] a, input [31:0] d, input s);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    tx_start <= s;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    tx_start <= 1'b0;
    #1;
  endtask
  task rd(input [3:0] a, input [31:0] x);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, x)
  endtask
  // one-hot walk over bus-off and the three messages, back to back
  task dbg(input integer f, input integer l);
    for (k = f; k <= l; k++) begin
      @(posedge clk_sys);
      {dbg_msg_c, dbg_msg_b, dbg_msg_a, bus_off} <= 4'h1 << k;
    end
    @(posedge clk_sys);
    {dbg_msg_c, dbg_msg_b, dbg_msg_a, bus_off} <= 4'h0;
    #1;
  endtask
  task results;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    results;
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(`CMDBG_OFS_CORE_CTRL, {24'h0, `CMDBG_CC_RESET});
    rd(`CMDBG_OFS_ID, `CMDBG_ID_VALUE);
    wr(4'hf, 32'hffffffff, 1'b0);
    rd(4'hf, 32'h0);
    $display("test reset done");
    for (i = 0; i < 6; i++) begin
      m = (i < 3) ? i : {$random(seed)} % 3;
      e = (m == 2) ? 3 : m;
      slow <= i[0];
      rd(`CMDBG_OFS_TX_PEND, 32'h0);
      wr(`CMDBG_OFS_CORE_CTRL, {26'h0, m[1:0], 4'h0}, 1'b0);
      wr(`CMDBG_OFS_TX_SET, 32'h1, 1'b0);
      wr(`CMDBG_OFS_TX_SET, 32'h0, 1'b1);
      q.push_back(e);
      `CHK({tx_brs, tx_fd}, e[1:0])
      repeat (12) @(posedge clk_sys);
      rd(`CMDBG_OFS_EVT_FIFO, q.pop_front());
    end
    // mode change from fd with switching to fd alone, same cycle as start;
    // the format in force before the write is the one captured
    wr(`CMDBG_OFS_CORE_CTRL, 32'h20, 1'b0);
    wr(`CMDBG_OFS_TX_SET, 32'h1, 1'b0);
    wr(`CMDBG_OFS_CORE_CTRL, 32'h10, 1'b1);
    q.push_back(3);
    `CHK({tx_brs, tx_fd}, 2'h3)
    repeat (12) @(posedge clk_sys);
    rd(`CMDBG_OFS_EVT_FIFO, q.pop_front());
    $display("test format done");
    wr(`CMDBG_OFS_IRQ_FLAGS, 32'h7, 1'b0);
    wr(`CMDBG_OFS_IRQ_MASK, 32'h1, 1'b0);
    wr(`CMDBG_OFS_TX_SET, 32'h1, 1'b0);
    wr(`CMDBG_OFS_CORE_CTRL, 32'h0, 1'b1);
    `CHK(tx_abort, 1'b1)
    rd(`CMDBG_OFS_IRQ_FLAGS, 32'h5);
    `CHK(irq, 1'b1)
    rd(`CMDBG_OFS_CORE_CTRL, 32'h4);
    rd(`CMDBG_OFS_EVT_STAT, 32'h0);
    wr(`CMDBG_OFS_IRQ_FLAGS, 32'h7, 1'b0);
    `CHK(irq, 1'b0)
    wr(`CMDBG_OFS_CORE_CTRL, 32'h1, 1'b0);
    wr(`CMDBG_OFS_CORE_CTRL, 32'h0, 1'b0);
    $display("test abort done");
    slow <= 1'b1;
    dbg(0, 3);
    `CHK(dma_req, 1'b1)
    repeat (12) @(posedge clk_sys);
    #1;
    `CHK(dma_req, 1'b0)
    rd(`CMDBG_OFS_RXF1_STAT, 32'h0);
    dbg(1, 2);
    wr(`CMDBG_OFS_CORE_CTRL, 32'h2, 1'b0);
    rd(`CMDBG_OFS_RXF1_STAT, 32'h2);
    dbg(0, 0);
    rd(`CMDBG_OFS_RXF1_STAT, 32'h0);
    dbg(1, 1);
    wr(`CMDBG_OFS_CORE_CTRL, 32'h1, 1'b0);
    rd(`CMDBG_OFS_RXF1_STAT, 32'h0);
    wr(`CMDBG_OFS_CORE_CTRL, 32'h0, 1'b0);
    dbg(1, 1);
    rd(`CMDBG_OFS_RXF1_STAT, 32'h1);
    dbg(1, 1);
    rd(`CMDBG_OFS_RXF1_STAT, 32'h0);
    // out-of-order third message while in the first state
    dbg(1, 1);
    dbg(3, 3);
    rd(`CMDBG_OFS_RXF1_STAT, 32'h0);
    $display("test debug done");
    results;
  end
endmodule
